// ### hdl/wasb_top.v
// wake-up source status and chip-select activity enable register bank
`timescale 1ns/100ps
`include "wasb_defines.vh"
module wasb_top (
    input  wire                       clk_sys_i,
    input  wire                       rst_b_i,
    input  wire                       ce_i,
    // index/data i/o pair
    input  wire                       io_sel_i,
    input  wire                       io_port_i,
    input  wire                       io_wr_i,
    input  wire                       io_rd_i,
    input  wire [7:0]                 io_wdata_i,
    output wire [7:0]                 io_rdata_o,
    // power state from the power manager, same clock
    input  wire                       asleep_i,
    // wake enables held elsewhere, same clock
    input  wire [`WASB_MISC_W-1:0]    misc_wake_en_i,
    input  wire [7:0]                 edge_wake_en_i,
    input  wire [7:0]                 dma_irq_wake_en_i,
    input  wire [`WASB_CARD_W-1:0]    card_wake_en_i,
    // asynchronous wake pins
    input  wire                       ring_in_b_i,
    input  wire                       mains_present_input_i,
    input  wire [2:0]                 battery_low_i,
    input  wire [`WASB_DMA_W-1:0]     prog_dma_req_i,
    input  wire [`WASB_IRQ_W-1:0]     prog_int_req_i,
    // same-clock event pulses; all but pin_evt_i can wake, pin events only set flags
    input  wire                       alarm_irq_i,
    input  wire                       suspend_pin_evt_i,
    input  wire [`WASB_CARD_W-1:0]    card_evt_i,
    input  wire [`WASB_PIN_W-1:0]     pin_evt_i,
    // general select decode hits, same clock pulses, bit 0 is decode A
    input  wire [`WASB_CS_W-1:0]      general_select_decode_i,
    output wire                       wake_o,
    output wire                       primary_act_o,
    output wire                       secondary_act_o
);
    localparam SYNC_W = 1 + 1 + 3 + `WASB_DMA_W + `WASB_IRQ_W;
    localparam REQ_W  = `WASB_DMA_W + `WASB_IRQ_W;

    // register state
    reg  [7:0]                 index_ff;
    reg  [7:0]                 rdata_ff;
    reg  [`WASB_MISC_W-1:0]    misc_ff;
    reg  [7:0]                 dma_irq_ff;
    reg  [`WASB_CARD_W-1:0]    card_ff;
    reg  [`WASB_PIN_LO_W-1:0]  pin_lo_ff;
    reg  [`WASB_PIN_HI_W-1:0]  pin_hi_ff;
    reg  [7:0]                 cs_en_ff;
    reg                        ring_prev_ff;
    reg  [REQ_W-1:0]           req_prev_ff;
    reg                        primed_ff;
    reg                        wake_ff;
    reg                        primary_ff;
    reg                        secondary_ff;

    reg  [7:0]                 nxt_rdata;
    wire [SYNC_W-1:0]          pin_sync;
    wire                       ring_s;
    wire                       mains_s;
    wire [2:0]                 batlow_s;
    wire [REQ_W-1:0]           req_s;

    // write decode
    wire                       data_wr;
    wire                       data_rd;
    wire                       wr_misc;
    wire                       wr_edge;
    wire                       wr_dma_irq;
    wire                       wr_card;
    wire                       wr_pin_lo;
    wire                       wr_pin_hi;
    wire                       wr_cs_en;

    // event and clear vectors
    wire [`WASB_MISC_W-1:0]    set_misc;
    wire [`WASB_MISC_W-1:0]    clr_misc;
    wire [REQ_W-1:0]           req_rise;
    wire [7:0]                 set_dma_irq;
    wire [7:0]                 clr_dma_irq;
    wire [`WASB_CARD_W-1:0]    set_card;
    wire [`WASB_CARD_W-1:0]    clr_card;
    wire [`WASB_PIN_LO_W-1:0]  clr_pin_lo;
    wire [`WASB_PIN_HI_W-1:0]  clr_pin_hi;
    wire [7:0]                 edge_field;
    wire [3:0]                 edge_wake;
    wire [3:0]                 edge_clr;
    wire [`WASB_CS_W-1:0]      cs_hit_act;
    wire [`WASB_CS_W-1:0]      cs_level;
    wire [`WASB_CS_W-1:0]      cs_enable;

    // all asynchronous pins pass two flops before use
    wasb_sync #(
        .WIDTH (SYNC_W)
    ) u_pin_sync (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .async_i   ({ring_in_b_i, mains_present_input_i, battery_low_i,
                     prog_dma_req_i, prog_int_req_i}),
        .sync_o    (pin_sync)
    );

    assign ring_s   = pin_sync[SYNC_W-1];
    assign mains_s  = pin_sync[SYNC_W-2];
    assign batlow_s = pin_sync[REQ_W+2:REQ_W];
    assign req_s    = pin_sync[REQ_W-1:0];

    // accesses to the data port address the indexed register
    assign data_wr    = io_sel_i & io_wr_i & (io_port_i == `WASB_PORT_DATA);
    assign data_rd    = io_sel_i & io_rd_i & (io_port_i == `WASB_PORT_DATA);
    assign wr_misc    = data_wr & (index_ff == `WASB_IDX_ST_MISC);
    assign wr_edge    = data_wr & (index_ff == `WASB_IDX_ST_EDGE);
    assign wr_dma_irq = data_wr & (index_ff == `WASB_IDX_ST_DMA_IRQ);
    assign wr_card    = data_wr & (index_ff == `WASB_IDX_ST_CARD);
    assign wr_pin_lo  = data_wr & (index_ff == `WASB_IDX_PIN_LOW);
    assign wr_pin_hi  = data_wr & (index_ff == `WASB_IDX_PIN_HIGH);
    assign wr_cs_en   = data_wr & (index_ff == `WASB_IDX_CS_EN);

    // a zero written to a flag clears it; a one leaves it alone
    assign clr_misc    = {`WASB_MISC_W{wr_misc}} & ~io_wdata_i[`WASB_MISC_W-1:0];
    assign clr_dma_irq = {8{wr_dma_irq}} & ~io_wdata_i;
    assign clr_card    = {`WASB_CARD_W{wr_card}} & ~io_wdata_i[`WASB_CARD_W-1:0];
    assign clr_pin_lo  = {`WASB_PIN_LO_W{wr_pin_lo}} & ~io_wdata_i;
    assign clr_pin_hi  = {`WASB_PIN_HI_W{wr_pin_hi}} & ~io_wdata_i[`WASB_PIN_HI_W-1:0];

    // single-bit wake sources only count while asleep and enabled
    assign set_misc[`WASB_BIT_RING]    = asleep_i & primed_ff & ring_prev_ff & ~ring_s
                                         & misc_wake_en_i[`WASB_BIT_RING];
    assign set_misc[`WASB_BIT_ALARM]   = asleep_i & alarm_irq_i
                                         & misc_wake_en_i[`WASB_BIT_ALARM];
    assign set_misc[`WASB_BIT_SUSPEND] = asleep_i & suspend_pin_evt_i
                                         & misc_wake_en_i[`WASB_BIT_SUSPEND];

    // request lines wake on their rising edge
    assign req_rise    = {REQ_W{primed_ff}} & req_s & ~req_prev_ff;
    assign set_dma_irq = {8{asleep_i}} & req_rise & dma_irq_wake_en_i;
    assign set_card    = {`WASB_CARD_W{asleep_i}} & card_evt_i & card_wake_en_i;

    // two-bit edge fields: mains, battery-low 2, 1, 0 from top to bottom
    assign edge_clr[3] = wr_edge & (io_wdata_i[`WASB_LSB_MAINS+1:`WASB_LSB_MAINS]
                         == `WASB_EDGE_NONE);
    assign edge_clr[2] = wr_edge & (io_wdata_i[`WASB_LSB_BATLOW2+1:`WASB_LSB_BATLOW2]
                         == `WASB_EDGE_NONE);
    assign edge_clr[1] = wr_edge & (io_wdata_i[`WASB_LSB_BATLOW1+1:`WASB_LSB_BATLOW1]
                         == `WASB_EDGE_NONE);
    assign edge_clr[0] = wr_edge & (io_wdata_i[`WASB_LSB_BATLOW0+1:`WASB_LSB_BATLOW0]
                         == `WASB_EDGE_NONE);

    wasb_edge_field u_mains_field (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .level_i   (mains_s),
        .asleep_i  (asleep_i),
        .wake_en_i (edge_wake_en_i[`WASB_LSB_MAINS+1:`WASB_LSB_MAINS]),
        .clear_i   (edge_clr[3]),
        .field_o   (edge_field[`WASB_LSB_MAINS+1:`WASB_LSB_MAINS]),
        .wake_o    (edge_wake[3])
    );

    wasb_edge_field u_batlow2_field (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .level_i   (batlow_s[2]),
        .asleep_i  (asleep_i),
        .wake_en_i (edge_wake_en_i[`WASB_LSB_BATLOW2+1:`WASB_LSB_BATLOW2]),
        .clear_i   (edge_clr[2]),
        .field_o   (edge_field[`WASB_LSB_BATLOW2+1:`WASB_LSB_BATLOW2]),
        .wake_o    (edge_wake[2])
    );

    wasb_edge_field u_batlow1_field (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .level_i   (batlow_s[1]),
        .asleep_i  (asleep_i),
        .wake_en_i (edge_wake_en_i[`WASB_LSB_BATLOW1+1:`WASB_LSB_BATLOW1]),
        .clear_i   (edge_clr[1]),
        .field_o   (edge_field[`WASB_LSB_BATLOW1+1:`WASB_LSB_BATLOW1]),
        .wake_o    (edge_wake[1])
    );

    wasb_edge_field u_batlow0_field (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .level_i   (batlow_s[0]),
        .asleep_i  (asleep_i),
        .wake_en_i (edge_wake_en_i[`WASB_LSB_BATLOW0+1:`WASB_LSB_BATLOW0]),
        .clear_i   (edge_clr[0]),
        .field_o   (edge_field[`WASB_LSB_BATLOW0+1:`WASB_LSB_BATLOW0]),
        .wake_o    (edge_wake[0])
    );

    // chip-select decode hits qualified by the enable half
    assign cs_level   = cs_en_ff[`WASB_LSB_CS_LEVEL+`WASB_CS_W-1:`WASB_LSB_CS_LEVEL];
    assign cs_enable  = cs_en_ff[`WASB_LSB_CS_EN+`WASB_CS_W-1:`WASB_LSB_CS_EN];
    assign cs_hit_act = general_select_decode_i & cs_enable;

    // flag, index and enable registers
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            index_ff     <= `WASB_RST_BYTE;
            misc_ff      <= {`WASB_MISC_W{1'b0}};
            dma_irq_ff   <= `WASB_RST_BYTE;
            card_ff      <= {`WASB_CARD_W{1'b0}};
            pin_lo_ff    <= {`WASB_PIN_LO_W{1'b0}};
            pin_hi_ff    <= {`WASB_PIN_HI_W{1'b0}};
            cs_en_ff     <= `WASB_RST_BYTE;
            ring_prev_ff <= 1'b0;
            req_prev_ff  <= {REQ_W{1'b0}};
            primed_ff    <= 1'b0;
        end else if (ce_i) begin
            if (io_sel_i && io_wr_i && io_port_i == `WASB_PORT_INDEX)
                index_ff <= io_wdata_i;
            // set is or-ed after the clear, so a same-cycle event survives
            misc_ff    <= (misc_ff & ~clr_misc) | set_misc;
            dma_irq_ff <= (dma_irq_ff & ~clr_dma_irq) | set_dma_irq;
            card_ff    <= (card_ff & ~clr_card) | set_card;
            pin_lo_ff  <= (pin_lo_ff & ~clr_pin_lo)
                          | pin_evt_i[`WASB_PIN_LO_W-1:0];
            pin_hi_ff  <= (pin_hi_ff & ~clr_pin_hi)
                          | pin_evt_i[`WASB_PIN_W-1:`WASB_PIN_LO_W];
            if (wr_cs_en)
                cs_en_ff <= io_wdata_i;
            ring_prev_ff <= ring_s;
            req_prev_ff  <= req_s;
            primed_ff    <= 1'b1;
        end
    end

    // read mux: reserved and unused bits read as zero
    always @* begin
        nxt_rdata = rdata_ff;
        if (io_sel_i && io_rd_i && io_port_i == `WASB_PORT_INDEX) begin
            nxt_rdata = index_ff;
        end else if (data_rd) begin
            case (index_ff)
                `WASB_IDX_ST_MISC:    nxt_rdata = {5'h00, misc_ff};
                `WASB_IDX_ST_EDGE:    nxt_rdata = edge_field;
                `WASB_IDX_ST_DMA_IRQ: nxt_rdata = dma_irq_ff;
                `WASB_IDX_ST_CARD:    nxt_rdata = {1'b0, card_ff};
                `WASB_IDX_PIN_LOW:    nxt_rdata = pin_lo_ff;
                `WASB_IDX_PIN_HIGH:   nxt_rdata = {1'b0, pin_hi_ff};
                `WASB_IDX_CS_EN:      nxt_rdata = cs_en_ff;
                default:              nxt_rdata = `WASB_RST_BYTE;
            endcase
        end
    end

    // read data is registered; reads change no state
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i)
            rdata_ff <= `WASB_RST_BYTE;
        else if (ce_i)
            rdata_ff <= nxt_rdata;
    end

    // activity and wake pulses, one cycle after their cause
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wake_ff      <= 1'b0;
            primary_ff   <= 1'b0;
            secondary_ff <= 1'b0;
        end else if (ce_i) begin
            wake_ff      <= (|set_misc) | (|set_dma_irq) | (|set_card) | (|edge_wake);
            primary_ff   <= |(cs_hit_act & cs_level);
            secondary_ff <= |(cs_hit_act & ~cs_level);
        end
    end

    assign io_rdata_o      = rdata_ff;
    assign wake_o          = wake_ff;
    assign primary_act_o   = primary_ff;
    assign secondary_act_o = secondary_ff;
endmodule // wasb_top

// ### hdl/wasb_defines.vh
// register indices, field positions and codes for the wake/activity status bank
`ifndef WASB_DEFINES_VH
`define WASB_DEFINES_VH

// port select of the index/data pair
`define WASB_PORT_INDEX      1'b0
`define WASB_PORT_DATA       1'b1

// register indices
`define WASB_IDX_ST_MISC     8'h56
`define WASB_IDX_ST_EDGE     8'h57
`define WASB_IDX_ST_DMA_IRQ  8'h58
`define WASB_IDX_ST_CARD     8'h59
`define WASB_IDX_PIN_LOW     8'h5A
`define WASB_IDX_PIN_HIGH    8'h5B
`define WASB_IDX_CS_EN       8'h60

// reset values
`define WASB_RST_BYTE        8'h00
`define WASB_RST_EDGE        2'h0

// edge logic waits for two sync stages plus one previous sample after reset
`define WASB_SETTLE_W        3

// misc status bits
`define WASB_BIT_RING        2
`define WASB_BIT_ALARM       1
`define WASB_BIT_SUSPEND     0
`define WASB_MISC_W          3

// edge status field lsb positions
`define WASB_LSB_MAINS       6
`define WASB_LSB_BATLOW2     4
`define WASB_LSB_BATLOW1     2
`define WASB_LSB_BATLOW0     0

// edge field codes
`define WASB_EDGE_NONE       2'h0
`define WASB_EDGE_FALL       2'h1
`define WASB_EDGE_RISE       2'h2
`define WASB_EN_FALL_BIT     0
`define WASB_EN_RISE_BIT     1

// dma/irq status fields
`define WASB_LSB_DMA         6
`define WASB_LSB_IRQ         0
`define WASB_DMA_W           2
`define WASB_IRQ_W           6

// card status bits
`define WASB_LSB_CARD        0
`define WASB_CARD_W          7

// general pin status
`define WASB_PIN_LO_W        8
`define WASB_PIN_HI_W        7
`define WASB_PIN_W           15

// chip-select enable fields
`define WASB_LSB_CS_LEVEL    4
`define WASB_LSB_CS_EN       0
`define WASB_CS_W            4

`endif

// ### hdl/wasb_sync.v
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module wasb_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk_sys_i,
    input  wire             rst_b_i,
    input  wire             ce_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // first stage feeds only the second stage
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else if (ce_i) begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule // wasb_sync

// ### hdl/wasb_edge_field.v
// one two-bit edge wake status field with its edge detector
`timescale 1ns/100ps
`include "wasb_defines.vh"
module wasb_edge_field (
    input  wire       clk_sys_i,
    input  wire       rst_b_i,
    input  wire       ce_i,
    input  wire       level_i,
    input  wire       asleep_i,
    input  wire [1:0] wake_en_i,
    input  wire       clear_i,
    output wire [1:0] field_o,
    output wire       wake_o
);
    reg        prev_ff;
    reg  [`WASB_SETTLE_W-1:0] primed_ff;
    reg  [1:0] field_ff;
    reg  [1:0] nxt_field;
    wire       rise;
    wire       fall;
    wire [1:0] evt_code;

    // the synchroniser comes out of reset at 0, so a pin already high would look like
    // a rise; edges count only once sync output and previous sample are both settled
    assign rise = primed_ff[`WASB_SETTLE_W-1] & level_i & ~prev_ff;
    assign fall = primed_ff[`WASB_SETTLE_W-1] & ~level_i & prev_ff;
    // only one edge can occur per cycle, so 11 is never produced
    assign evt_code = (asleep_i & rise & wake_en_i[`WASB_EN_RISE_BIT]) ? `WASB_EDGE_RISE :
                      (asleep_i & fall & wake_en_i[`WASB_EN_FALL_BIT]) ? `WASB_EDGE_FALL :
                      `WASB_EDGE_NONE;
    assign wake_o  = (evt_code != `WASB_EDGE_NONE);
    assign field_o = field_ff;

    // first recorded edge is kept; a new edge beats a same-cycle clear
    always @* begin
        nxt_field = field_ff;
        if (clear_i)
            nxt_field = `WASB_EDGE_NONE;
        if (wake_o && (clear_i || field_ff == `WASB_EDGE_NONE))
            nxt_field = evt_code;
    end

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_ff   <= 1'b0;
            primed_ff <= {`WASB_SETTLE_W{1'b0}};
            field_ff  <= `WASB_RST_EDGE;
        end else if (ce_i) begin
            prev_ff   <= level_i;
            primed_ff <= {primed_ff[`WASB_SETTLE_W-2:0], 1'b1};
            field_ff  <= nxt_field;
        end
    end
endmodule // wasb_edge_field

// ### testbench/wasb_top_asserts.sv
// port checks for the wake/activity status bank
`timescale 1ns/100ps
module wasb_top_asserts (
    input wire logic       clk_sys_i,
    input wire logic       rst_b_i,
    input wire logic       ce_i,
    input wire logic       io_sel_i,
    input wire logic       io_rd_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic       asleep_i,
    input wire logic [2:0] misc_wake_en_i,
    input wire logic [6:0] card_wake_en_i,
    input wire logic       ring_in_b_i,
    input wire logic       alarm_irq_i,
    input wire logic       suspend_pin_evt_i,
    input wire logic [6:0] card_evt_i,
    input wire logic [14:0] pin_evt_i,
    input wire logic [3:0] general_select_decode_i,
    input wire logic       wake_o,
    input wire logic       primary_act_o,
    input wire logic       secondary_act_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // a wake can only land while clocked and asleep
    wire live = ce_i && asleep_i;
    a_alarm_wake: assert property (live && misc_wake_en_i[1] && alarm_irq_i |=> wake_o)
        else $error("alarm event gave no wake pulse");
    a_suspend_wake: assert property (live && misc_wake_en_i[0] && suspend_pin_evt_i |=> wake_o)
        else $error("suspend pin event gave no wake pulse");
    a_card_wake: assert property (live && |(card_evt_i & card_wake_en_i) |=> wake_o)
        else $error("card event gave no wake pulse");
    // ring pin passes two sync flops first, so allow a short window
    a_ring_wake: assert property (live && misc_wake_en_i[2] && $fell(ring_in_b_i) |-> ##[2:4] wake_o)
        else $error("ring falling edge gave no wake pulse");
    a_wake_asleep: assert property (wake_o |-> $past(asleep_i) || $past(|pin_evt_i))
        else $error("wake pulse while awake");
    a_decode_cause: assert property (primary_act_o || secondary_act_o |-> $past(|general_select_decode_i))
        else $error("activity pulse without a decode hit");
    a_reset_quiet: assert property ($rose(rst_b_i) |-> !wake_o && !primary_act_o && !secondary_act_o && io_rdata_o == 8'h00)
        else $error("outputs not quiet after reset");
    a_rdata_hold: assert property (!$past(io_sel_i && io_rd_i && ce_i) |-> $stable(io_rdata_o))
        else $error("read data moved without a read");
    c_primary: cover property (primary_act_o);
    c_secondary: cover property (secondary_act_o);
    c_alarm: cover property (live && alarm_irq_i ##1 wake_o);
endmodule // wasb_top_asserts

bind wasb_top wasb_top_asserts u_chk (.clk_sys_i, .rst_b_i, .ce_i, .io_sel_i, .io_rd_i,
    .io_rdata_o, .asleep_i, .misc_wake_en_i, .card_wake_en_i, .ring_in_b_i, .alarm_irq_i,
    .suspend_pin_evt_i, .card_evt_i, .pin_evt_i, .general_select_decode_i, .wake_o,
    .primary_act_o, .secondary_act_o);

// ### testbench/wasb_sw_model.sv
// software side of the index/data register pair
`timescale 1ns/100ps
module wasb_sw_model (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] rdata_i,
    output logic            sel_o,
    output logic            port_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic [7:0]      wdata_o
);
    initial begin
        {sel_o, port_o, wr_o, rd_o, wdata_o} = 12'h000;
    end
    // released lines show the inverse so stale data never looks valid
    task automatic wr(input logic p, input logic [7:0] d);
        @(posedge clk_sys_i);
        sel_o <= 1'b1;
        port_o <= p;
        wr_o <= 1'b1;
        wdata_o <= d;
        @(posedge clk_sys_i);
        sel_o <= 1'b0;
        wr_o <= 1'b0;
        port_o <= ~p;
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic p, output logic [7:0] d);
        @(posedge clk_sys_i);
        sel_o <= 1'b1;
        port_o <= p;
        rd_o <= 1'b1;
        @(posedge clk_sys_i);
        sel_o <= 1'b0;
        rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask
    // read then write back, reserved bits carried over from the read
    task automatic rmw(input logic [7:0] idx, k, rsv, output logic [7:0] v, w);
        wr(1'b0, idx);
        rd(1'b1, v);
        w = (k & ~rsv) | (v & rsv);
        wr(1'b1, w);
    endtask
endmodule // wasb_sw_model

// ### testbench/wasb_top_tb.sv
// self-checking bench for the wake/activity status bank
`timescale 1ns/100ps
`include "wasb_defines.vh"
module wasb_top_tb;
    logic clk_sys_i, rst_b_i, ce_i, asleep_i, ring_in_b_i, mains_present_input_i;
    logic alarm_irq_i, suspend_pin_evt_i, wake_o, primary_act_o, secondary_act_o;
    logic io_sel_i, io_port_i, io_wr_i, io_rd_i;
    logic [7:0]  io_wdata_i, io_rdata_o, edge_wake_en_i, dma_irq_wake_en_i;
    logic [2:0]  misc_wake_en_i, battery_low_i;
    logic [1:0]  prog_dma_req_i;
    logic [5:0]  prog_int_req_i;
    logic [6:0]  card_wake_en_i, card_evt_i;
    logic [14:0] pin_evt_i, p;
    logic [3:0]  general_select_decode_i, d;
    logic [7:0]  c, v;
    integer      seed = 45;
    int          err_count = 0, total_checks = 0, cyc = 0;
    int          m [7];
    logic [7:0]  ix [7] = '{`WASB_IDX_ST_MISC, `WASB_IDX_ST_EDGE, `WASB_IDX_ST_DMA_IRQ,
        `WASB_IDX_ST_CARD, `WASB_IDX_PIN_LOW, `WASB_IDX_PIN_HIGH, `WASB_IDX_CS_EN};
    logic [7:0]  rs [7] = '{8'hF8, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00};

    wasb_top DUT (.clk_sys_i, .rst_b_i, .ce_i, .io_sel_i, .io_port_i, .io_wr_i, .io_rd_i,
        .io_wdata_i, .io_rdata_o, .asleep_i, .misc_wake_en_i, .edge_wake_en_i,
        .dma_irq_wake_en_i, .card_wake_en_i, .ring_in_b_i, .mains_present_input_i,
        .battery_low_i, .prog_dma_req_i, .prog_int_req_i, .alarm_irq_i, .suspend_pin_evt_i,
        .card_evt_i, .pin_evt_i, .general_select_decode_i, .wake_o, .primary_act_o,
        .secondary_act_o);
    wasb_sw_model u_sw (.clk_sys_i, .rdata_i(io_rdata_o), .sel_o(io_sel_i), .port_o(io_port_i),
        .wr_o(io_wr_i), .rd_o(io_rd_i), .wdata_o(io_wdata_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            final_report;
        end
    end
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // model of a write: edge fields clear only on 00, the chip-select enables load the written byte, others clear on 0
    function automatic int upd(int s, int o, logic [7:0] w);
        int r;
        r = o & w;
        if (s == 6) r = w;
        if (s == 1) begin
            r = o;
            for (int f = 0; f < 8; f += 2) if (w[f+:2] == 2'h0) r[f+:2] = 2'h0;
        end
        return r;
    endfunction
    task automatic rc(int s, logic [7:0] k);
        logic [7:0] w;
        u_sw.rmw(ix[s], k, rs[s], v, w);
        chk($sformatf("reg %h", ix[s]), m[s][7:0], v);
        m[s] = upd(s, m[s], w);
    endtask
    task final_report;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        {rst_b_i, ce_i, asleep_i, ring_in_b_i, mains_present_input_i} = 5'b01010;
        {alarm_irq_i, suspend_pin_evt_i, misc_wake_en_i, battery_low_i} = 8'h00;
        {edge_wake_en_i, dma_irq_wake_en_i, card_wake_en_i, card_evt_i} = 30'h0;
        {prog_dma_req_i, prog_int_req_i, pin_evt_i, general_select_decode_i} = 27'h0;
        for (int s = 0; s < 7; s++) m[s] = 0;
        repeat (16) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        for (int s = 0; s < 6; s++) rc(s, 8'hFF);
        rc(6, 8'h00);
        u_sw.wr(1'b0, 8'h61);
        u_sw.wr(1'b1, 8'hFF);
        u_sw.rd(1'b1, v);
        chk("unmapped", 8'h00, v);
        u_sw.rd(1'b0, v);
        chk("index", 8'h61, v);
        // decode hits against random level and enable settings
        repeat (8) begin
            c = 8'($random(seed));
            d = 4'($random(seed));
            u_sw.wr(1'b0, `WASB_IDX_CS_EN);
            u_sw.wr(1'b1, c);
            m[6] = c;
            @(posedge clk_sys_i);
            general_select_decode_i <= d;
            @(posedge clk_sys_i);
            general_select_decode_i <= 4'h0;
            #1;
            chk("primary", {7'h00, |(d & c[3:0] & c[7:4])}, {7'h00, primary_act_o});
            chk("secondary", {7'h00, |(d & c[3:0] & ~c[7:4])}, {7'h00, secondary_act_o});
        end
        rc(6, 8'h0F);
        // every single-bit source, once asleep and once awake
        for (int it = 0; it < 2; it++) begin
            @(posedge clk_sys_i);
            asleep_i <= (it == 0);
            misc_wake_en_i <= 3'($random(seed));
            dma_irq_wake_en_i <= 8'($random(seed));
            card_wake_en_i <= 7'($random(seed));
            ring_in_b_i <= 1'b0;
            {prog_dma_req_i, prog_int_req_i} <= 8'hFF;
            @(posedge clk_sys_i);
            {alarm_irq_i, suspend_pin_evt_i, card_evt_i} <= 9'h1FF;
            @(posedge clk_sys_i);
            {alarm_irq_i, suspend_pin_evt_i, card_evt_i} <= 9'h000;
            // pulses were sampled at this edge; pin edges arrive later through the sync
            #1;
            c = {7'h00, (it == 0) && (|misc_wake_en_i[1:0] || |card_wake_en_i)};
            chk("wake", c, {7'h00, wake_o});
            repeat (5) @(posedge clk_sys_i);
            ring_in_b_i <= 1'b1;
            {prog_dma_req_i, prog_int_req_i} <= 8'h00;
            m[0] = (it == 0) ? misc_wake_en_i : 0;
            m[2] = (it == 0) ? dma_irq_wake_en_i : 0;
            m[3] = (it == 0) ? card_wake_en_i : 0;
            rc(0, 8'h00);
            rc(2, 8'h00);
            rc(3, 8'h00);
        end
        // each edge enable code on all four two-bit fields
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys_i);
            asleep_i <= 1'b1;
            edge_wake_en_i <= {4{2'(k)}};
            {mains_present_input_i, battery_low_i} <= 4'hF;
            repeat (5) @(posedge clk_sys_i);
            {mains_present_input_i, battery_low_i} <= 4'h0;
            repeat (5) @(posedge clk_sys_i);
            m[1] = (k == 1) ? 8'h55 : (k > 1) ? 8'hAA : 8'h00;
            rc(1, 8'h00);
        end
        // pin flags ignore the sleep state
        p = 15'($random(seed));
        @(posedge clk_sys_i);
        asleep_i <= 1'b0;
        pin_evt_i <= p;
        @(posedge clk_sys_i);
        pin_evt_i <= 15'h0;
        m[4] = p[7:0];
        m[5] = p[14:8];
        rc(4, 8'($random(seed)));
        rc(4, 8'hFF);
        rc(5, 8'h00);
        // a new event in the clearing cycle must survive
        u_sw.wr(1'b0, `WASB_IDX_PIN_LOW);
        fork
            u_sw.wr(1'b1, 8'h00);
            begin
                @(posedge clk_sys_i);
                pin_evt_i <= 15'h0001;
                @(posedge clk_sys_i);
                pin_evt_i <= 15'h0;
            end
        join
        m[4] = 1;
        rc(4, 8'h00);
        final_report;
    end
endmodule // wasb_top_tb
